// ---- rtl/conv_ctl_pkg.sv ----
package conv_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the apb bus
  localparam logic [7:0] MODE_CFG_A_OFS = 8'h00;
  localparam logic [7:0] MODE_CFG_B_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] CONV_COUNT_OFS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // mode_cfg_a fields
  localparam int MODE_A_W = 10;
  localparam int FILTER_LSB = 0;
  localparam int FILTER_W = 3;
  localparam int CONV_MODE_BIT = 4;
  localparam int RATE_LSB = 5;
  localparam int RATE_W = 5;
  localparam logic [9:0] MODE_A_RST = 10'h000;

  // mode_cfg_b fields
  localparam int MODE_B_W = 7;
  localparam int DELAY_LSB = 0;
  localparam int DELAY_W = 4;
  localparam int CHOP_BIT = 4;
  localparam int AC_EXC_BIT = 5;
  localparam int CRC_BIT = 6;
  localparam logic [6:0] MODE_B_RST = 7'h01;

  // status and interrupt bits
  localparam int ST_RUN_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_CFG_OK_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CFG_ERR_BIT = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam int COUNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // filter field encodings
  localparam logic [2:0] FILT_FIRST_ORDER_AVG = 3'h0;
  localparam logic [2:0] FILT_SINC2 = 3'h1;
  localparam logic [2:0] FILT_SINC3 = 3'h2;
  localparam logic [2:0] FILT_SINC4 = 3'h3;
  localparam logic [2:0] FILT_FIR = 3'h4;
  localparam logic [2:0] FILT_SINC5 = 3'h5;

  // rate codes: 0..16 = 2.5, 5, 10, 16.6, 20, 50, 60, 100, 400, 1200,
  // 2400, 4800, 7200, 14400, 19200, 25600, 40000 samples per second
  localparam logic [4:0] RATE_20 = 5'h04;
  localparam logic [4:0] RATE_7200 = 5'h0C;
  localparam logic [4:0] RATE_40000 = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // serial command frame
  localparam logic [7:0] OP_START = 8'h5A;
  localparam logic [7:0] OP_STOP = 8'hA5;
  localparam logic [5:0] EDGE_NO_CRC = 6'h10;
  localparam logic [5:0] EDGE_CRC = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // timing, clock and tick periods in ns, the other durations counted in microsecond ticks
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int LAT_W = 23;
  localparam int START_DELAY_US = 50;
  localparam int PROC_US = 350;
  localparam int FIR_EXTRA_US = 1800;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } conv_state_t;

  // one output period in microseconds
  function automatic logic [22:0] period_us(input logic [4:0] rate);
    case (rate)
      5'h00: period_us = 23'h061A80;
      5'h01: period_us = 23'h030D40;
      5'h02: period_us = 23'h0186A0;
      5'h03: period_us = 23'h00EA60;
      5'h04: period_us = 23'h00C350;
      5'h05: period_us = 23'h004E20;
      5'h06: period_us = 23'h00411B;
      5'h07: period_us = 23'h002710;
      5'h08: period_us = 23'h0009C4;
      5'h09: period_us = 23'h000341;
      5'h0A: period_us = 23'h0001A1;
      5'h0B: period_us = 23'h0000D0;
      5'h0C: period_us = 23'h00008B;
      5'h0D: period_us = 23'h000045;
      5'h0E: period_us = 23'h000034;
      5'h0F: period_us = 23'h000027;
      default: period_us = 23'h000019;
    endcase
  endfunction : period_us

endpackage : conv_ctl_pkg

// ---- rtl/cmd_frame_rx.sv ----
`timescale 1ns/10ps
module cmd_frame_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic crc_en,
  output logic cmd_start,
  output logic cmd_stop
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;
  logic [5:0] edge_cnt_q;
  logic [7:0] opcode_q;
  logic fall;
  logic [5:0] take_edge;

  ////////////////////////////////////////////////////////////////////////////
  // the serial clock is sampled, never used as a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q <= {cs_n, sclk, din};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[1];
    end
  end

  assign fall = sclk_prev_q & ~sync_q[1] & ~sync_q[2];
  assign take_edge = crc_en ? conv_ctl_pkg::EDGE_CRC
                            : conv_ctl_pkg::EDGE_NO_CRC;

  ////////////////////////////////////////////////////////////////////////////
  // chip select high aborts a partial frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_q <= 6'h00;
      opcode_q <= 8'h00;
    end else if (sync_q[2]) begin
      edge_cnt_q <= 6'h00;
    end else if (fall && edge_cnt_q != 6'h3F) begin
      edge_cnt_q <= edge_cnt_q + 6'h01;
      if (edge_cnt_q < 6'h08) begin
        opcode_q <= {opcode_q[6:0], sync_q[0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
    end else begin
      cmd_start <= fall && !sync_q[2] && edge_cnt_q + 6'h01 == take_edge &&
                   opcode_q == conv_ctl_pkg::OP_START;
      cmd_stop <= fall && !sync_q[2] && edge_cnt_q + 6'h01 == take_edge &&
                  opcode_q == conv_ctl_pkg::OP_STOP;
    end
  end

endmodule : cmd_frame_rx

// ---- rtl/adc_conversion_control.sv ----
`timescale 1ns/10ps
module adc_conversion_control #(
  parameter int TICK_CYCLES = conv_ctl_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_pin,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic result_ready_n,
  output logic irq
);

  localparam int LW = conv_ctl_pkg::LAT_W;

  logic [conv_ctl_pkg::MODE_A_W-1:0] mode_a_q;
  logic [conv_ctl_pkg::MODE_B_W-1:0] mode_b_q;
  logic [conv_ctl_pkg::IRQ_W-1:0] irq_st_q;
  logic [conv_ctl_pkg::IRQ_W-1:0] irq_mask_q;
  logic [conv_ctl_pkg::IRQ_W-1:0] irq_set;
  logic [conv_ctl_pkg::COUNT_W-1:0] conv_count_q;
  conv_ctl_pkg::conv_state_t state_q;
  logic [LW-1:0] remain_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic pin_rise;
  logic pin_fall;
  logic cmd_start;
  logic cmd_stop;
  logic start_evt;
  logic stop_evt;
  logic start_ok;
  logic stop_pend_q;
  logic pulse_run_q;
  logic done;
  logic wr_en;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [2:0] filt;
  logic [4:0] rate;
  logic [3:0] dly_code;
  logic chop_like;
  logic rate_ok;
  logic [2:0] order;
  logic [LW-1:0] per;
  logic [LW-1:0] dly_us;
  logic [LW-1:0] single_lat;
  logic [LW-1:0] first_len;
  logic [LW-1:0] follow_len;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  // rate, filter, delay and chop fields
  assign filt = mode_a_q[conv_ctl_pkg::FILTER_LSB +: conv_ctl_pkg::FILTER_W];
  assign rate = mode_a_q[conv_ctl_pkg::RATE_LSB +: conv_ctl_pkg::RATE_W];
  assign dly_code = mode_b_q[conv_ctl_pkg::DELAY_LSB +: conv_ctl_pkg::DELAY_W];
  assign chop_like = mode_b_q[conv_ctl_pkg::CHOP_BIT] |
                     mode_b_q[conv_ctl_pkg::AC_EXC_BIT];
  assign per = conv_ctl_pkg::period_us(rate);

  always_comb begin
    case (filt)
      conv_ctl_pkg::FILT_FIR: begin
        rate_ok = rate <= conv_ctl_pkg::RATE_20 && rate != 5'h03;
      end
      conv_ctl_pkg::FILT_FIRST_ORDER_AVG, conv_ctl_pkg::FILT_SINC2,
      conv_ctl_pkg::FILT_SINC3, conv_ctl_pkg::FILT_SINC4: begin
        rate_ok = rate <= conv_ctl_pkg::RATE_7200;
      end
      conv_ctl_pkg::FILT_SINC5: begin
        rate_ok = rate > conv_ctl_pkg::RATE_7200 &&
                  rate <= conv_ctl_pkg::RATE_40000;
      end
      default: begin
        rate_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (filt)
      conv_ctl_pkg::FILT_SINC2: order = 3'h2;
      conv_ctl_pkg::FILT_SINC3: order = 3'h3;
      conv_ctl_pkg::FILT_SINC4: order = 3'h4;
      conv_ctl_pkg::FILT_SINC5: order = 3'h5;
      default: order = 3'h1;
    endcase
  end

  always_comb begin
    if (dly_code == 4'h0) begin
      dly_us = '0;
    end else begin
      dly_us = LW'(conv_ctl_pkg::START_DELAY_US) << (dly_code - 4'h1);
    end
  end

  assign single_lat = LW'(per * order) + dly_us +
                      LW'(conv_ctl_pkg::PROC_US) +
                      ((filt == conv_ctl_pkg::FILT_FIR) ?
                       LW'(conv_ctl_pkg::FIR_EXTRA_US) : '0);
  assign first_len = chop_like ? LW'({single_lat, 1'b0}) : single_lat;
  assign follow_len = chop_like ? single_lat : per;

  ////////////////////////////////////////////////////////////////////////////
  // start pin synchroniser and edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= start_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // edge only, a held-high pin never restarts
  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;

  cmd_frame_rx u_cmd (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .crc_en(mode_b_q[conv_ctl_pkg::CRC_BIT]),
    .cmd_start(cmd_start),
    .cmd_stop(cmd_stop)
  );

  assign start_evt = pin_rise | cmd_start;
  assign stop_evt = pin_fall | cmd_stop;
  assign start_ok = start_evt & rate_ok;

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick, realigned on every accepted start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
    end else if (start_ok || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign tick = tick_cnt_q == 16'(TICK_CYCLES - 1);
  assign done = state_q == conv_ctl_pkg::ST_RUN && tick &&
                remain_q == LW'(1) && !start_ok;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= conv_ctl_pkg::ST_IDLE;
      remain_q <= '0;
      pulse_run_q <= 1'b0;
    end else if (start_ok) begin
      state_q <= conv_ctl_pkg::ST_RUN;
      remain_q <= first_len;
      // mode held for the whole run
      pulse_run_q <= mode_a_q[conv_ctl_pkg::CONV_MODE_BIT];
    end else if (done) begin
      if (pulse_run_q || stop_pend_q || stop_evt) begin
        state_q <= conv_ctl_pkg::ST_IDLE;
      end
      remain_q <= follow_len;
    end else if (state_q == conv_ctl_pkg::ST_RUN && tick) begin
      remain_q <= remain_q - LW'(1);
    end
  end

  // stop pending only in continuous runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_pend_q <= 1'b0;
    end else if (start_ok || state_q == conv_ctl_pkg::ST_IDLE) begin
      stop_pend_q <= 1'b0;
    end else if (stop_evt && !pulse_run_q) begin
      stop_pend_q <= 1'b1;
    end
  end

  // data ready framing; a fresh continuous conversion raises it a tick
  // after the result so the host sees a low window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_n <= 1'b1;
    end else if (start_ok) begin
      result_ready_n <= 1'b1;
    end else if (done) begin
      result_ready_n <= 1'b0;
    end else if (state_q == conv_ctl_pkg::ST_RUN && tick) begin
      result_ready_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_count_q <= '0;
    end else if (done) begin
      conv_count_q <= conv_count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign wr_en = psel & penable & pwrite & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a_q <= conv_ctl_pkg::MODE_A_RST;
      mode_b_q <= conv_ctl_pkg::MODE_B_RST;
      irq_mask_q <= conv_ctl_pkg::IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        conv_ctl_pkg::MODE_CFG_A_OFS: begin
          mode_a_q <= pwdata[conv_ctl_pkg::MODE_A_W-1:0];
        end
        conv_ctl_pkg::MODE_CFG_B_OFS: begin
          mode_b_q <= pwdata[conv_ctl_pkg::MODE_B_W-1:0];
        end
        conv_ctl_pkg::IRQ_MASK_OFS: begin
          irq_mask_q <= pwdata[conv_ctl_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[conv_ctl_pkg::IRQ_DONE_BIT] = done;
    irq_set[conv_ctl_pkg::IRQ_CFG_ERR_BIT] = start_evt & ~rate_ok;
    irq_set[conv_ctl_pkg::IRQ_STOP_BIT] = stop_evt &
                                          (state_q == conv_ctl_pkg::ST_RUN);
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else if (wr_en && paddr == conv_ctl_pkg::IRQ_STATUS_OFS) begin
      irq_st_q <= (irq_st_q & ~pwdata[conv_ctl_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      conv_ctl_pkg::MODE_CFG_A_OFS: rd_mux = 32'(mode_a_q);
      conv_ctl_pkg::MODE_CFG_B_OFS: rd_mux = 32'(mode_b_q);
      conv_ctl_pkg::STATUS_OFS: begin
        rd_mux[conv_ctl_pkg::ST_RUN_BIT] = state_q == conv_ctl_pkg::ST_RUN;
        rd_mux[conv_ctl_pkg::ST_READY_BIT] = ~result_ready_n;
        rd_mux[conv_ctl_pkg::ST_CFG_OK_BIT] = rate_ok;
      end
      conv_ctl_pkg::IRQ_STATUS_OFS: rd_mux = 32'(irq_st_q);
      conv_ctl_pkg::IRQ_MASK_OFS: rd_mux = 32'(irq_mask_q);
      conv_ctl_pkg::CONV_COUNT_OFS: rd_mux = 32'(conv_count_q);
      default: rd_hit = 1'b0;
    endcase
  end

  // answer registered in the setup cycle, valid throughout the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

endmodule : adc_conversion_control

// ---- dv/conv_ctl_sva.sv ----
`timescale 1ns/10ps
module conv_ctl_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_pin,
  input wire logic result_ready_n,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
  logic [9:0] cfg_a_q;
  logic [4:0] cfg_rate;
  logic cfg_ok;
  // mirror of mode_cfg_a: a start refused for its filter and rate pairing
  // leaves the ready line as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_q <= conv_ctl_pkg::MODE_A_RST;
    end else if (psel && penable && pready && pwrite &&
                 paddr == conv_ctl_pkg::MODE_CFG_A_OFS) begin
      cfg_a_q <= pwdata[9:0];
    end
  end
  assign cfg_rate = cfg_a_q[9:5];
  always_comb begin
    case (cfg_a_q[2:0])
      conv_ctl_pkg::FILT_FIR: begin
        cfg_ok = cfg_rate <= conv_ctl_pkg::RATE_20 && cfg_rate != 5'h03;
      end
      conv_ctl_pkg::FILT_SINC5: begin
        cfg_ok = cfg_rate > conv_ctl_pkg::RATE_7200 &&
                 cfg_rate <= conv_ctl_pkg::RATE_40000;
      end
      3'h6, 3'h7: begin
        cfg_ok = 1'b0;
      end
      default: begin
        cfg_ok = cfg_rate <= conv_ctl_pkg::RATE_7200;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  property p_err_unmapped;
    pslverr |-> pready && !mapped;
  endproperty
  property p_ok_mapped;
    pready && mapped |-> !pslverr;
  endproperty
  property p_rdata_idle;
    !(pready && !pwrite) |-> prdata == 32'h0;
  endproperty
  property p_mask_off;
    pready && pwrite && paddr == 8'h10 && pwdata[2:0] == 3'h0 |=> ##1 !irq;
  endproperty
  // a rise of the pin starts or restarts, so ready goes high within 6
  property p_start_resp;
    $rose(start_pin) && cfg_ok |-> ##[1:6] result_ready_n;
  endproperty
  // no output period is shorter than 25 ticks, so low follows a long high
  property p_fall_after_high;
    $fell(result_ready_n) |-> $past(result_ready_n, 20);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer to setup");
  a_one_cycle: assert property (p_one_cycle) else $error("pready too long");
  a_err_unmapped: assert property (p_err_unmapped) else $error("bad pslverr");
  a_ok_mapped: assert property (p_ok_mapped) else $error("pslverr on map");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not 0");
  a_mask_off: assert property (p_mask_off) else $error("irq while masked");
  a_start_resp: assert property (p_start_resp)
    else $error("start not seen");
  a_fall_after_high: assert property (p_fall_after_high)
    else $error("result too early");
endmodule : conv_ctl_sva
bind adc_conversion_control conv_ctl_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .start_pin, .result_ready_n, .irq);

// ---- dv/spi_cmd_host.sv ----
`timescale 1ns/10ps
module spi_cmd_host (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // frame of 16 or 32 falls, opcode msb first
  // caller keeps the start pin low while commands are used
  task automatic send(input logic [31:0] frame, input int nclk);
    // chip select stays high a full link period, so back to back frames
    // still reset the edge counter
    #160;
    cs_n <= 1'b0;
    #80;
    for (int i = 0; i < nclk; i++) begin
      sclk <= 1'b1;
      din <= frame[31 - i];
      #80;
      sclk <= 1'b0;
      #80;
    end
    cs_n <= 1'b1;
    // released line shows the inverse, clock stands still low
    din <= ~din;
  endtask : send
endmodule : spi_cmd_host

// ---- dv/test_adc_conversion_control.sv ----
`timescale 1ns/10ps
module test_adc_conversion_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic start_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sclk, cs_n, din, result_ready_n, irq;
  logic [31:0] seed = 32'h70367C66;
  logic [31:0] rd;
  logic err;
  logic [1:0] dly;
  int miscompares = 0;
  int n_tests = 0;
  int n;
  int l;
  always #5 pclk = ~pclk;
  adc_conversion_control #(.TICK_CYCLES(1)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .start_pin, .sclk, .cs_n, .din, .result_ready_n, .irq);
  spi_cmd_host u_host (.sclk, .cs_n, .din);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // first latency in ticks: period times order, delay, processing
  function automatic int lat(int per, int ord, int code, bit chop);
    lat = per * ord + (code == 0 ? 0 : 50 << (code - 1)) + 350;
    if (chop) lat = 2 * lat;
  endfunction : lat
  task automatic end_sim;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic cmp_lat(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : cmp_lat
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] e, logic ee);
    apb(1'b0, a, 32'h0);
    cmp_reg(rd, e);
    cmp_bit(err, ee);
  endtask : chk
  task automatic wait_fall(output int cnt);
    logic seen;
    seen = 1'b0;
    cnt = 0;
    while (!(seen && result_ready_n === 1'b0) && cnt < 3000) begin
      @(posedge pclk);
      cnt++;
      if (result_ready_n === 1'b1) seen = 1'b1;
    end
  endtask : wait_fall
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(8'h00, 32'h0, 1'b0);
    chk(8'h04, 32'h1, 1'b0);
    chk(8'h08, 32'h4, 1'b0);
    chk(8'h10, 32'h0, 1'b0);
    chk(8'h14, 32'h0, 1'b0);
    chk(8'h18, 32'h0, 1'b1);
    apb(1'b1, 8'h1C, seed);
    cmp_bit(err, 1'b1);
    $display("test reset done");
    seed = lfsr(seed);
    dly = (seed[1:0] == 2'h3) ? 2'h1 : seed[1:0];
    apb(1'b1, 8'h00, 32'h180);
    apb(1'b1, 8'h04, {seed[31:7], 7'(dly)});
    apb(1'b1, 8'h10, 32'h1);
    @(posedge pclk);
    start_pin <= 1'b1;
    wait_fall(n);
    l = lat(139, 1, dly, 1'b0);
    cmp_lat(n, l, l + 8);
    wait_fall(n);
    cmp_lat(n, 139, 139);
    repeat (2) @(posedge pclk);
    cmp_bit(irq, 1'b1);
    start_pin <= 1'b0;
    wait_fall(n);
    cmp_lat(n, 1, 139);
    repeat (400) @(posedge pclk);
    cmp_bit(result_ready_n, 1'b0);
    chk(8'h14, 32'h3, 1'b0);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h0C, 32'h7);
    chk(8'h0C, 32'h0, 1'b0);
    cmp_bit(irq, 1'b0);
    $display("test continuous done");
    apb(1'b1, 8'h00, 32'h205);
    apb(1'b1, 8'h04, 32'h11);
    u_host.send({conv_ctl_pkg::OP_START, 24'h0}, 16);
    repeat (200) @(posedge pclk);
    u_host.send({conv_ctl_pkg::OP_START, 24'h0}, 16);
    wait_fall(n);
    l = lat(25, 5, 1, 1'b1);
    cmp_lat(n, l - 12, l + 8);
    wait_fall(n);
    cmp_lat(n, 525, 525);
    u_host.send({conv_ctl_pkg::OP_STOP, 24'h0}, 16);
    wait_fall(n);
    cmp_lat(n, 1, 525);
    repeat (1100) @(posedge pclk);
    cmp_bit(result_ready_n, 1'b0);
    $display("test chop done");
    apb(1'b1, 8'h00, 32'h215);
    apb(1'b1, 8'h04, 32'h1);
    @(posedge pclk);
    start_pin <= 1'b1;
    repeat (200) @(posedge pclk);
    start_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    start_pin <= 1'b1;
    wait_fall(n);
    cmp_lat(n, 525, 533);
    repeat (1100) @(posedge pclk);
    cmp_bit(result_ready_n, 1'b0);
    chk(8'h14, 32'h7, 1'b0);
    chk(8'h08, 32'h6, 1'b0);
    start_pin <= 1'b0;
    apb(1'b1, 8'h04, 32'h62);
    u_host.send({conv_ctl_pkg::OP_START, 24'h0}, 16);
    repeat (1100) @(posedge pclk);
    cmp_bit(result_ready_n, 1'b0);
    u_host.send({conv_ctl_pkg::OP_START, 24'h0}, 32);
    u_host.send({conv_ctl_pkg::OP_STOP, 24'h0}, 32);
    wait_fall(n);
    l = lat(25, 5, 2, 1'b1);
    cmp_lat(n, l - 545, l - 530);
    chk(8'h14, 32'h8, 1'b0);
    $display("test pulse done");
    apb(1'b1, 8'h00, 32'h204);
    apb(1'b1, 8'h0C, 32'h7);
    @(posedge pclk);
    start_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    cmp_bit(rd[1], 1'b1);
    cmp_bit(result_ready_n, 1'b0);
    $display("test config error done");
    end_sim();
  end
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
endmodule : test_adc_conversion_control
